/* File: hw/ppc_defines.vh */
// Register map, field positions and reset values of the pin configuration
`ifndef PPC_DEFINES_VH
`define PPC_DEFINES_VH

// Register addresses
`define PPC_ADDR_SPD 8'hB0
`define PPC_ADDR_P0A 8'hB1
`define PPC_ADDR_P0B 8'hB2
`define PPC_ADDR_P1A 8'hB3
`define PPC_ADDR_P1B 8'hB4
`define PPC_ADDR_SPT 8'hB5
`define PPC_ADDR_SMA 8'hAC
`define PPC_ADDR_SMB 8'hAD

// Page select values
`define PPC_PAGE_MODE 1'h0
`define PPC_PAGE_TYPE 1'h1

// Reset values
`define PPC_RST_MODE_A 8'hFF
`define PPC_RST_MODE_B 8'h00
`define PPC_RST_TYPE 8'h00
`define PPC_RST_SLEW 8'h00
`define PPC_RST_SPD 1'h1
`define PPC_RST_SMA 1'h1
`define PPC_RST_SMB 1'h0
`define PPC_RST_SPT 1'h0

// Special pin and timer output field positions
`define PPC_SPT_PULLUP 7
`define PPC_SPT_T1OE 3
`define PPC_SPT_TIMER_ZERO_PIN_OUTPUT_ENABLE 2
`define PPC_SPT_ITYPE 0

// Mode codes, first select bit then second
`define PPC_MODE_QUASI 2'h0
`define PPC_MODE_PUSH 2'h1
`define PPC_MODE_INPUT 2'h2
`define PPC_MODE_DRAIN 2'h3

`endif

/* File: hw/ppc_mode_decode.v */
// Per-pin decode of the two mode select bits into driver controls
`timescale 1ns/10ps
`default_nettype none
`include "ppc_defines.vh"

module ppc_mode_decode #(
  parameter WIDTH = 8
) (
  // Mode select bit pairs
  input wire [WIDTH-1:0] sel_a_in,
  input wire [WIDTH-1:0] sel_b_in,
  // Driver controls
  output wire [WIDTH-1:0] strong_high_out,
  output wire [WIDTH-1:0] weak_pullup_out,
  output wire [WIDTH-1:0] drive_low_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_pin
      wire [1:0] code;
      assign code = {sel_a_in[i], sel_b_in[i]};
      // decode mode pair
      // Input-only is the one code with every driver off
      assign strong_high_out[i] = (code == `PPC_MODE_PUSH);
      assign weak_pullup_out[i] = (code == `PPC_MODE_QUASI);
      assign drive_low_out[i] = (code != `PPC_MODE_INPUT);
    end
  endgenerate

endmodule

`default_nettype wire

/* File: hw/ppc_top.v */
// Pin configuration registers for two byte ports and a single-pin port
//
// Functional notes
// - Mode pair decodes to four driver modes
// - Byte port pins reset to input-only
// - Input type bit: 0 TTL, 1 Schmitt
// - Slew bit: 0 normal, 1 fast
// - Single-pin data upper bits read zero
// - Single pin is GPIO only on internal oscillator
// - Oscillator use ignores pin data writes, pin data reads zero
// - Bit 7 enables special pin pull-up
// - Pull-up bit acts only when option is 0
// - Reset pin keeps pull-up always on
// - Bit 3 routes timer one to pin
// - Bit 2 routes timer zero to pin
// - Single pin has own mode pair
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "ppc_defines.vh"

module ppc_top #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire mclk_in,
  input wire rst_n_in,
  // Register port
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire reg_page_in,
  output reg [7:0] reg_rdata_out,
  // System state
  input wire internal_osc_sel_in,
  input wire reset_pin_disable_option_in,
  input wire timer_zero_in,
  input wire timer_one_in,
  // Port zero pin controls
  output reg [WIDTH-1:0] p0_strong_high_out,
  output reg [WIDTH-1:0] p0_weak_pullup_out,
  output reg [WIDTH-1:0] p0_drive_low_out,
  output reg [WIDTH-1:0] p0_schmitt_out,
  output reg [WIDTH-1:0] p0_fast_slew_out,
  // Port one pin controls
  output reg [WIDTH-1:0] p1_strong_high_out,
  output reg [WIDTH-1:0] p1_weak_pullup_out,
  output reg [WIDTH-1:0] p1_drive_low_out,
  output reg [WIDTH-1:0] p1_schmitt_out,
  output reg [WIDTH-1:0] p1_fast_slew_out,
  // Single pin controls
  output reg sp_data_out,
  output reg sp_gpio_en_out,
  output reg sp_strong_high_out,
  output reg sp_weak_pullup_out,
  output reg sp_drive_low_out,
  output reg sp_schmitt_out,
  output reg sp_fast_slew_out,
  // Special pin and timer pins
  output reg special_pin_pullup_out,
  output reg special_pin_schmitt_out,
  output reg timer_zero_pin_en_out,
  output reg timer_zero_pin_out,
  output reg timer_one_pin_en_out,
  output reg timer_one_pin_out
);

  // Stored configuration
  reg [WIDTH-1:0] p0_mode_a_reg;
  reg [WIDTH-1:0] p0_mode_b_reg;
  reg [WIDTH-1:0] p0_itype_reg;
  reg [WIDTH-1:0] p0_slew_reg;
  reg [WIDTH-1:0] p1_mode_a_reg;
  reg [WIDTH-1:0] p1_mode_b_reg;
  reg [WIDTH-1:0] p1_itype_reg;
  reg [WIDTH-1:0] p1_slew_reg;
  reg sp_data_reg;
  reg sp_mode_a_reg;
  reg sp_mode_b_reg;
  reg sp_itype_reg;
  reg sp_slew_reg;
  reg pullup_en_reg;
  reg t1_oe_reg;
  reg t0_oe_reg;
  reg special_itype_reg;
  reg [7:0] rdata_next;

  // Decoded driver controls
  wire [WIDTH-1:0] p0_sh;
  wire [WIDTH-1:0] p0_wp;
  wire [WIDTH-1:0] p0_dl;
  wire [WIDTH-1:0] p1_sh;
  wire [WIDTH-1:0] p1_wp;
  wire [WIDTH-1:0] p1_dl;
  wire [0:0] sp_sh;
  wire [0:0] sp_wp;
  wire [0:0] sp_dl;

  // Address and page qualifiers
  wire pg_mode;
  wire pg_type;
  wire wr_spd;
  wire wr_spt;
  wire wr_p0a;
  wire wr_p0b;
  wire wr_p1a;
  wire wr_p1b;
  wire wr_sma;
  wire wr_smb;

  assign pg_mode = (reg_page_in == `PPC_PAGE_MODE);
  assign pg_type = (reg_page_in == `PPC_PAGE_TYPE);
  assign wr_spd = reg_wr_in && (reg_addr_in == `PPC_ADDR_SPD);
  assign wr_spt = reg_wr_in && (reg_addr_in == `PPC_ADDR_SPT);
  assign wr_p0a = reg_wr_in && (reg_addr_in == `PPC_ADDR_P0A);
  assign wr_p0b = reg_wr_in && (reg_addr_in == `PPC_ADDR_P0B);
  assign wr_p1a = reg_wr_in && (reg_addr_in == `PPC_ADDR_P1A);
  assign wr_p1b = reg_wr_in && (reg_addr_in == `PPC_ADDR_P1B);
  assign wr_sma = reg_wr_in && (reg_addr_in == `PPC_ADDR_SMA);
  assign wr_smb = reg_wr_in && (reg_addr_in == `PPC_ADDR_SMB);

  // Byte port configuration registers
  always @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      p0_mode_a_reg <= `PPC_RST_MODE_A;
      p0_mode_b_reg <= `PPC_RST_MODE_B;
      p1_mode_a_reg <= `PPC_RST_MODE_A;
      p1_mode_b_reg <= `PPC_RST_MODE_B;
      p0_itype_reg <= `PPC_RST_TYPE;
      p0_slew_reg <= `PPC_RST_SLEW;
      p1_itype_reg <= `PPC_RST_TYPE;
      p1_slew_reg <= `PPC_RST_SLEW;
    end
    else
    begin
      if (wr_p0a && pg_mode)
        p0_mode_a_reg <= reg_wdata_in[WIDTH-1:0];
      if (wr_p0a && pg_type)
        p0_itype_reg <= reg_wdata_in[WIDTH-1:0];
      if (wr_p0b && pg_mode)
        p0_mode_b_reg <= reg_wdata_in[WIDTH-1:0];
      if (wr_p0b && pg_type)
        p0_slew_reg <= reg_wdata_in[WIDTH-1:0];
      if (wr_p1a && pg_mode)
        p1_mode_a_reg <= reg_wdata_in[WIDTH-1:0];
      if (wr_p1a && pg_type)
        p1_itype_reg <= reg_wdata_in[WIDTH-1:0];
      if (wr_p1b && pg_mode)
        p1_mode_b_reg <= reg_wdata_in[WIDTH-1:0];
      if (wr_p1b && pg_type)
        p1_slew_reg <= reg_wdata_in[WIDTH-1:0];
    end
  end

  // Single pin and special pin registers
  always @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      sp_data_reg <= `PPC_RST_SPD;
      sp_mode_a_reg <= `PPC_RST_SMA;
      sp_mode_b_reg <= `PPC_RST_SMB;
      sp_itype_reg <= `PPC_RST_SPT;
      sp_slew_reg <= `PPC_RST_SPT;
      pullup_en_reg <= `PPC_RST_SPT;
      t1_oe_reg <= `PPC_RST_SPT;
      t0_oe_reg <= `PPC_RST_SPT;
      special_itype_reg <= `PPC_RST_SPT;
    end
    else
    begin
      if (wr_spd && internal_osc_sel_in)
        sp_data_reg <= reg_wdata_in[0];
      if (wr_sma && pg_mode)
        sp_mode_a_reg <= reg_wdata_in[0];
      if (wr_sma && pg_type)
        sp_itype_reg <= reg_wdata_in[0];
      if (wr_smb && pg_mode)
        sp_mode_b_reg <= reg_wdata_in[0];
      if (wr_smb && pg_type)
        sp_slew_reg <= reg_wdata_in[0];
      // Special register has no page; both pages reach it
      if (wr_spt)
      begin
        pullup_en_reg <= reg_wdata_in[`PPC_SPT_PULLUP];
        t1_oe_reg <= reg_wdata_in[`PPC_SPT_T1OE];
        t0_oe_reg <= reg_wdata_in[`PPC_SPT_TIMER_ZERO_PIN_OUTPUT_ENABLE];
        special_itype_reg <= reg_wdata_in[`PPC_SPT_ITYPE];
      end
    end
  end

  // Read multiplexer; unmapped addresses and idle cycles give zero
  always @*
  begin
    rdata_next = 8'h00;
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        `PPC_ADDR_SPD:
          rdata_next = {7'h00, sp_data_reg & internal_osc_sel_in};
        `PPC_ADDR_P0A:
          rdata_next = pg_type ? p0_itype_reg : p0_mode_a_reg;
        `PPC_ADDR_P0B:
          rdata_next = pg_type ? p0_slew_reg : p0_mode_b_reg;
        `PPC_ADDR_P1A:
          rdata_next = pg_type ? p1_itype_reg : p1_mode_a_reg;
        `PPC_ADDR_P1B:
          rdata_next = pg_type ? p1_slew_reg : p1_mode_b_reg;
        `PPC_ADDR_SMA:
          rdata_next = {7'h00, pg_type ? sp_itype_reg : sp_mode_a_reg};
        `PPC_ADDR_SMB:
          rdata_next = {7'h00, pg_type ? sp_slew_reg : sp_mode_b_reg};
        `PPC_ADDR_SPT:
        begin
          rdata_next[`PPC_SPT_PULLUP] = pullup_en_reg;
          rdata_next[`PPC_SPT_T1OE] = t1_oe_reg;
          rdata_next[`PPC_SPT_TIMER_ZERO_PIN_OUTPUT_ENABLE] = t0_oe_reg;
          rdata_next[`PPC_SPT_ITYPE] = special_itype_reg;
        end
        default:
          rdata_next = 8'h00;
      endcase
    end
  end

  // Read data stands for exactly the cycle after the strobe
  always @(posedge mclk_in)
  begin
    if (!rst_n_in)
      reg_rdata_out <= 8'h00;
    else
      reg_rdata_out <= rdata_next;
  end

  // Mode decoders, one per port
  ppc_mode_decode #(
    .WIDTH(WIDTH)
  ) u_p0_dec (
    .sel_a_in(p0_mode_a_reg),
    .sel_b_in(p0_mode_b_reg),
    .strong_high_out(p0_sh),
    .weak_pullup_out(p0_wp),
    .drive_low_out(p0_dl)
  );

  ppc_mode_decode #(
    .WIDTH(WIDTH)
  ) u_p1_dec (
    .sel_a_in(p1_mode_a_reg),
    .sel_b_in(p1_mode_b_reg),
    .strong_high_out(p1_sh),
    .weak_pullup_out(p1_wp),
    .drive_low_out(p1_dl)
  );

  ppc_mode_decode #(
    .WIDTH(1)
  ) u_sp_dec (
    .sel_a_in(sp_mode_a_reg),
    .sel_b_in(sp_mode_b_reg),
    .strong_high_out(sp_sh),
    .weak_pullup_out(sp_wp),
    .drive_low_out(sp_dl)
  );

  // Byte port pad controls, retimed so pads see glitch-free levels
  always @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      p0_strong_high_out <= {WIDTH{1'b0}};
      p0_weak_pullup_out <= {WIDTH{1'b0}};
      p0_drive_low_out <= {WIDTH{1'b0}};
      p0_schmitt_out <= {WIDTH{1'b0}};
      p0_fast_slew_out <= {WIDTH{1'b0}};
      p1_strong_high_out <= {WIDTH{1'b0}};
      p1_weak_pullup_out <= {WIDTH{1'b0}};
      p1_drive_low_out <= {WIDTH{1'b0}};
      p1_schmitt_out <= {WIDTH{1'b0}};
      p1_fast_slew_out <= {WIDTH{1'b0}};
    end
    else
    begin
      p0_strong_high_out <= p0_sh;
      p0_weak_pullup_out <= p0_wp;
      p0_drive_low_out <= p0_dl;
      p1_strong_high_out <= p1_sh;
      p1_weak_pullup_out <= p1_wp;
      p1_drive_low_out <= p1_dl;
      p0_schmitt_out <= p0_itype_reg;
      p1_schmitt_out <= p1_itype_reg;
      p0_fast_slew_out <= p0_slew_reg;
      p1_fast_slew_out <= p1_slew_reg;
    end
  end

  // Single pin pad controls
  always @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      sp_data_out <= 1'b0;
      sp_gpio_en_out <= 1'b0;
      sp_strong_high_out <= 1'b0;
      sp_weak_pullup_out <= 1'b0;
      sp_drive_low_out <= 1'b0;
      sp_schmitt_out <= 1'b0;
      sp_fast_slew_out <= 1'b0;
    end
    else
    begin
      // GPIO only on internal clock
      // Drivers are gated off so the oscillator input is never loaded
      sp_gpio_en_out <= internal_osc_sel_in;
      sp_data_out <= sp_data_reg & internal_osc_sel_in;
      sp_strong_high_out <= sp_sh[0] & internal_osc_sel_in;
      sp_weak_pullup_out <= sp_wp[0] & internal_osc_sel_in;
      sp_drive_low_out <= sp_dl[0] & internal_osc_sel_in;
      sp_schmitt_out <= sp_itype_reg;
      sp_fast_slew_out <= sp_slew_reg;
    end
  end

  // Special pin and timer routing
  always @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      special_pin_pullup_out <= 1'b1;
      special_pin_schmitt_out <= 1'b0;
      timer_zero_pin_en_out <= 1'b0;
      timer_zero_pin_out <= 1'b0;
      timer_one_pin_en_out <= 1'b0;
      timer_one_pin_out <= 1'b0;
    end
    else
    begin
      if (reset_pin_disable_option_in == 1'b0)
        special_pin_pullup_out <= pullup_en_reg;
      else
        special_pin_pullup_out <= 1'b1;
      special_pin_schmitt_out <= special_itype_reg;
      timer_zero_pin_en_out <= t0_oe_reg;
      timer_zero_pin_out <= t0_oe_reg & timer_zero_in;
      timer_one_pin_en_out <= t1_oe_reg;
      timer_one_pin_out <= t1_oe_reg & timer_one_in;
    end
  end

endmodule

`default_nettype wire

/* File: dv/ppc_board_model.sv */
// Board-side stand-in that supplies the two timer output levels
`timescale 1ns/10ps
`default_nettype none

module ppc_board_model (
  // Clock
  input wire logic mclk_in,
  // Timer levels
  output wire logic timer_zero_out,
  output wire logic timer_one_out
);
  logic [2:0] cnt_reg = 3'h0;

  // Free count, valid from time zero so the levels are never unknown
  always @(posedge mclk_in)
  begin
    cnt_reg <= cnt_reg + 3'h1;
  end

  // Unequal periods so a swapped timer route shows up
  assign timer_zero_out = cnt_reg[0];
  assign timer_one_out = cnt_reg[2];
endmodule

`default_nettype wire

/* File: dv/ppc_checker_properties.sv */
// Concurrent checks on the pin configuration block ports
`timescale 1ns/10ps
`default_nettype none

module ppc_checker #(
  parameter WIDTH = 8
) (
  // Clock, reset and register port
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // System state
  input wire logic internal_osc_sel_in,
  input wire logic reset_pin_disable_option_in,
  input wire logic timer_zero_in,
  input wire logic timer_one_in,
  // Pin controls
  input wire logic [WIDTH-1:0] p0_strong_high_out,
  input wire logic [WIDTH-1:0] p0_weak_pullup_out,
  input wire logic [WIDTH-1:0] p0_drive_low_out,
  input wire logic sp_data_out,
  input wire logic sp_strong_high_out,
  input wire logic sp_drive_low_out,
  input wire logic special_pin_pullup_out,
  input wire logic timer_zero_pin_en_out,
  input wire logic timer_zero_pin_out,
  input wire logic timer_one_pin_en_out,
  input wire logic timer_one_pin_out
);
  // One clock domain, so one default clock and reset
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  // High drivers always come with the low driver enabled
  mode_pair_legal_a: assert property (
    !(|(((p0_strong_high_out | p0_weak_pullup_out) & ~p0_drive_low_out)
      | (p0_strong_high_out & p0_weak_pullup_out))))
    else $error("port zero driver mix illegal");
  sp_osc_gate_a: assert property (
    !$past(internal_osc_sel_in) |->
      !sp_data_out && !sp_strong_high_out && !sp_drive_low_out)
    else $error("single pin driven while oscillator input");
  sp_read_zero_a: assert property (
    reg_rd_in && reg_addr_in == 8'hB0 && !internal_osc_sel_in |=>
      reg_rdata_out == 8'h00)
    else $error("single pin read not zero on oscillator");
  spd_upper_zero_a: assert property (
    reg_rd_in && reg_addr_in == 8'hB0 |=> reg_rdata_out[7:1] == 7'h00)
    else $error("single pin data upper bits not zero");
  spt_reserved_zero_a: assert property (
    reg_rd_in && reg_addr_in == 8'hB5 |=> (reg_rdata_out & 8'h72) == 8'h00)
    else $error("special pin reserved bits not zero");
  pullup_forced_a: assert property (
    $past(reset_pin_disable_option_in) |-> special_pin_pullup_out)
    else $error("reset pin pull-up not forced on");
  // Bit 7 reaches the pull-up one cycle after the write lands
  pullup_bit_a: assert property (
    (reg_wr_in && reg_addr_in == 8'hB5) ##1 !reset_pin_disable_option_in
      |=> {special_pin_pullup_out, 7'h00} == ($past(reg_wdata_in, 2) & 8'h80))
    else $error("pull-up does not follow written bit");
  t0_route_a: assert property (
    $past(rst_n_in) |-> timer_zero_pin_out ==
      (timer_zero_pin_en_out && $past(timer_zero_in)))
    else $error("timer zero pin route wrong");
  t1_route_a: assert property (
    $past(rst_n_in) |-> timer_one_pin_out ==
      (timer_one_pin_en_out && $past(timer_one_in)))
    else $error("timer one pin route wrong");
endmodule

bind ppc_top ppc_checker #(.WIDTH(WIDTH)) u_chk (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .internal_osc_sel_in(internal_osc_sel_in),
  .reset_pin_disable_option_in(reset_pin_disable_option_in),
  .timer_zero_in(timer_zero_in), .timer_one_in(timer_one_in),
  .p0_strong_high_out(p0_strong_high_out),
  .p0_weak_pullup_out(p0_weak_pullup_out),
  .p0_drive_low_out(p0_drive_low_out), .sp_data_out(sp_data_out),
  .sp_strong_high_out(sp_strong_high_out),
  .sp_drive_low_out(sp_drive_low_out),
  .special_pin_pullup_out(special_pin_pullup_out),
  .timer_zero_pin_en_out(timer_zero_pin_en_out),
  .timer_zero_pin_out(timer_zero_pin_out),
  .timer_one_pin_en_out(timer_one_pin_en_out),
  .timer_one_pin_out(timer_one_pin_out));

`default_nettype wire

/* File: dv/tb.sv */
// Register-level testbench of the pin configuration block
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic page = 1'b0;
  logic osc = 1'b1;
  logic opt = 1'b0;
  wire logic t0, t1, sp_d, pu, t0_en, t0_pin, t1_en, t1_pin;
  wire logic sp_gen, sp_shi, sp_wpu, sp_dlo, sp_sch, sp_fsl, pin_st;
  wire logic [7:0] rdata, p0_sh, p0_wp, p0_dl, p0_st, p1_fs;
  wire logic [7:0] p1_sh, p1_wp, p1_dl, p1_st, p0_fs;
  wire logic [7:0] sp_ctl;
  // Timer levels caught before the edge at which the pins take them
  logic [1:0] tl = 2'h0;
  int n_mismatch = 0;
  int checks = 0;
  // Reset table: address, page (bit per entry) and expected value
  logic [7:0] ra [13] = '{8'hB0, 8'hB1, 8'hB1, 8'hB2, 8'hB2, 8'hB3, 8'hB3,
    8'hB4, 8'hB4, 8'hB5, 8'hAC, 8'hAD, 8'hB6};
  logic [12:0] rp = 13'h0154;
  logic [7:0] re [13] = '{8'h01, 8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};

  ppc_top #(.WIDTH(8)) DUT (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_page_in(page), .reg_rdata_out(rdata),
    .internal_osc_sel_in(osc), .reset_pin_disable_option_in(opt),
    .timer_zero_in(t0), .timer_one_in(t1),
    .p0_strong_high_out(p0_sh), .p0_weak_pullup_out(p0_wp),
    .p0_drive_low_out(p0_dl), .p0_schmitt_out(p0_st),
    .p0_fast_slew_out(p0_fs), .p1_strong_high_out(p1_sh),
    .p1_weak_pullup_out(p1_wp), .p1_drive_low_out(p1_dl),
    .p1_schmitt_out(p1_st), .p1_fast_slew_out(p1_fs),
    .sp_data_out(sp_d), .sp_gpio_en_out(sp_gen),
    .sp_strong_high_out(sp_shi), .sp_weak_pullup_out(sp_wpu),
    .sp_drive_low_out(sp_dlo), .sp_schmitt_out(sp_sch),
    .sp_fast_slew_out(sp_fsl), .special_pin_pullup_out(pu),
    .special_pin_schmitt_out(pin_st), .timer_zero_pin_en_out(t0_en),
    .timer_zero_pin_out(t0_pin), .timer_one_pin_en_out(t1_en),
    .timer_one_pin_out(t1_pin));

  // Single pin controls gathered for one compare
  assign sp_ctl = {2'h0, sp_gen, sp_shi, sp_wpu, sp_dlo, sp_sch, sp_fsl};

  ppc_board_model u_board (
    .mclk_in(mclk_in), .timer_zero_out(t0), .timer_one_out(t1));

  // 200 MHz clock
  initial
  begin
    forever #2.5 mclk_in = ~mclk_in;
  end

  task automatic chk(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle write strobe; a gap cycle keeps strobes from merging
  task automatic wreg(input logic [7:0] a, input logic pg,
    input logic [7:0] d);
    @(posedge mclk_in);
    addr <= a;
    page <= pg;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rreg(input logic [7:0] a, input logic pg,
    input logic [7:0] e);
    @(posedge mclk_in);
    addr <= a;
    page <= pg;
    rd <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), e, rdata);
  endtask

  // Pin controls lag their register by one cycle
  task automatic settle;
    @(posedge mclk_in);
    #1;
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Hang guard, far beyond the hundred or so cycles the tests need
  initial
  begin
    #100000;
    n_mismatch++;
    summarize;
  end

  // Main sequence
  initial
  begin
    repeat (4) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 13; i++)
      rreg(ra[i], rp[i], re[i]);
    chk("drive low", 8'h00, p0_dl | p0_wp | p0_sh);
    wreg(8'hB6, 1'b0, 8'hFF);
    rreg(8'hB6, 1'b0, 8'h00);
    $display("test reset values done");
    wreg(8'hB1, 1'b0, 8'h0C);
    wreg(8'hB2, 1'b0, 8'h0A);
    settle;
    chk("strong high", 8'h02, p0_sh);
    chk("weak pullup", 8'hF1, p0_wp);
    chk("drive low", 8'hFB, p0_dl);
    // Port one: two drain, two input, two push-pull, two quasi pins
    wreg(8'hB3, 1'b0, 8'hF0);
    wreg(8'hB4, 1'b0, 8'hCC);
    settle;
    chk("p1 strong high", 8'h0C, p1_sh);
    chk("p1 weak pullup", 8'h03, p1_wp);
    chk("p1 drive low", 8'hCF, p1_dl);
    $display("test mode decode done");
    wreg(8'hB1, 1'b1, 8'hA5);
    wreg(8'hB4, 1'b1, 8'h3C);
    wreg(8'hB3, 1'b1, 8'h5A);
    wreg(8'hB2, 1'b1, 8'hC3);
    settle;
    chk("schmitt", 8'hA5, p0_st);
    chk("fast slew", 8'h3C, p1_fs);
    chk("p1 schmitt", 8'h5A, p1_st);
    chk("p0 fast slew", 8'hC3, p0_fs);
    rreg(8'hB1, 1'b0, 8'h0C);
    rreg(8'hB4, 1'b0, 8'hCC);
    rreg(8'hB3, 1'b0, 8'hF0);
    rreg(8'hB3, 1'b1, 8'h5A);
    $display("test pages done");
    wreg(8'hB0, 1'b0, 8'hFE);
    rreg(8'hB0, 1'b0, 8'h00);
    wreg(8'hB0, 1'b0, 8'hFF);
    settle;
    chk("pin data", 8'h01, {7'h00, sp_d});
    // Push-pull single pin with Schmitt input and fast edges
    wreg(8'hAC, 1'b0, 8'h00);
    wreg(8'hAD, 1'b0, 8'h01);
    wreg(8'hAC, 1'b1, 8'h01);
    wreg(8'hAD, 1'b1, 8'h01);
    settle;
    chk("pin controls", 8'h37, sp_ctl);
    rreg(8'hAD, 1'b0, 8'h01);
    rreg(8'hAC, 1'b1, 8'h01);
    @(posedge mclk_in);
    osc <= 1'b0;
    wreg(8'hB0, 1'b0, 8'h00);
    rreg(8'hB0, 1'b0, 8'h00);
    chk("pin data", 8'h00, {7'h00, sp_d});
    chk("pin controls", 8'h03, sp_ctl);
    @(posedge mclk_in);
    osc <= 1'b1;
    rreg(8'hB0, 1'b0, 8'h01);
    $display("test single pin done");
    // Timers stand in timer mode here, so enabling their pins is allowed
    wreg(8'hB5, 1'b0, 8'hFF);
    rreg(8'hB5, 1'b0, 8'h8D);
    chk("pullup", 8'h01, {7'h00, pu});
    chk("timer enables", 8'h03, {6'h00, t1_en, t0_en});
    chk("special schmitt", 8'h01, {7'h00, pin_st});
    // Two cycles, so both levels of the faster timer reach its pin
    repeat (2)
    begin
      @(negedge mclk_in);
      tl = {t1, t0};
      settle;
      chk("timer pins", {6'h00, tl}, {6'h00, t1_pin, t0_pin});
    end
    wreg(8'hB5, 1'b0, 8'h00);
    settle;
    chk("pullup", 8'h00, {7'h00, pu});
    chk("timer enables", 8'h00, {6'h00, t1_en, t0_en});
    chk("special schmitt", 8'h00, {7'h00, pin_st});
    repeat (2)
    begin
      settle;
      chk("timer pins", 8'h00, {6'h00, t1_pin, t0_pin});
    end
    @(posedge mclk_in);
    opt <= 1'b1;
    settle;
    chk("pullup", 8'h01, {7'h00, pu});
    $display("test special pin done");
    summarize;
  end
endmodule

`default_nettype wire
